// ---- hw/ecc_edge_prescaler.sv ----
`timescale 1ns/1ns
module ecc_edge_prescaler (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_clear,
  input wire logic i_rise,
  input wire logic [3:0] i_wrap_at,
  output logic o_wrap
);
  logic [3:0] count_q;

  assign o_wrap = i_rise && (count_q == i_wrap_at);

  always_ff @(posedge i_clk) begin
    if (i_rst || i_clear) begin
      count_q <= 4'h0;
    end else if (o_wrap) begin
      count_q <= 4'h0;
    end else if (i_rise) begin
      count_q <= count_q + 4'h1;
    end
  end
endmodule : ecc_edge_prescaler

// ---- hw/ecc_pkg.sv ----
package ecc_pkg;
  // wishbone word byte addresses
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_VALUE_LOW = 4'h4;
  localparam logic [3:0] ADDR_VALUE_HIGH = 4'h8;
  localparam logic [3:0] ADDR_FLAGS = 4'hc;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  // control field positions
  localparam int MODE_LSB = 0;
  localparam int DUTY_LSB = 4;
  localparam int STEER_LSB = 6;
  // flags register bits
  localparam int FLAG_EVENT_BIT = 0;
  localparam int FLAG_ENABLE_BIT = 1;
  localparam int FLAG_ADC_EN_BIT = 2;
  // mode codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
  localparam logic [3:0] MODE_CMP_SPECIAL = 4'hb;
  localparam logic [3:0] MODE_PWM_HH = 4'hc;
  localparam logic [3:0] MODE_PWM_HL = 4'hd;
  localparam logic [1:0] PWM_TOP = 2'h3;
  localparam logic [1:0] STEER_SINGLE = 2'h0;
  localparam logic [1:0] STEER_FWD = 2'h1;
  localparam logic [1:0] STEER_HALF = 2'h2;
  localparam logic [3:0] PRESCALE_MAX4 = 4'h3;
  localparam logic [3:0] PRESCALE_MAX16 = 4'hf;
endpackage : ecc_pkg

// ---- hw/ecc_unit.sv ----
// Overview of operation
// - off code clears compare latch and prescaler only
// - capture codes pick edge and divide
// - capture copies full 16-bit timer count
// - capture sets flag; software clears it
// - new capture overwrites old silently
// - edges seen on actual pin level
// - prescaler cleared when off, noncapture, reset
// - prescale code change keeps counter
// - compare pair checked against timer every cycle
// - toggle/set/clear output on match, flag
// - soft interrupt mode: flag only
// - special event: flag, timer reset, conversion
// - pwm codes set output polarities
// - code 1111 same polarity as 1110
// - steering field picks output arrangement
// - non-pwm: steering ignored, a is pin
// - duty low bits only used in pwm
// - event now, timer reset next tick
// - special event leaves overflow flag alone
`timescale 1ns/1ns
module ecc_unit (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic [15:0] i_timer_one_count,
  input wire logic i_timer_one_tick,
  input wire logic i_event_pin,
  input wire logic i_pwm_active,
  output logic o_event_pin,
  output logic o_event_pin_oe_n,
  output logic o_drive_out_b,
  output logic o_drive_out_c,
  output logic o_drive_out_d,
  output logic [3:0] o_steer_owned,
  output logic [9:0] o_duty,
  output logic o_unit_event_flag,
  output logic o_unit_event_irq,
  output logic o_special_event,
  output logic o_timer_one_reset,
  output logic o_adc_start
);
  //////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ECC_CLASS_OFF = 3'b001,
    ECC_CLASS_CAP = 3'b010,
    ECC_CLASS_CMP = 3'b100
  } ecc_class_t;

  logic [7:0] control_q;
  logic [15:0] value_q;
  logic event_flag_q;
  logic irq_enable_q;
  logic adc_enable_q;
  logic pin_meta_q;
  logic pin_sync_q;
  logic pin_prev_q;
  logic cmp_latch_q;
  logic match_q;
  logic special_q;
  logic ack_q;
  logic [31:0] rdata_q;

  logic [3:0] mode;
  logic [1:0] steer;
  logic is_pwm;
  ecc_class_t mode_class;
  logic rise;
  logic fall;
  logic wrap;
  logic capture;
  logic match;
  logic hit;
  logic wr_en;
  logic rd_en;

  function automatic logic [15:0] ecc_merge(input logic [15:0] old,
                                            input logic [31:0] dat,
                                            input logic [31:0] m);
    ecc_merge = (old & ~m[15:0]) | (dat[15:0] & m[15:0]);
  endfunction : ecc_merge

  assign mode = control_q[ecc_pkg::MODE_LSB +: 4];
  assign steer = control_q[ecc_pkg::STEER_LSB +: 2];
  assign is_pwm = (mode[3:2] == ecc_pkg::PWM_TOP);

  always_comb begin
    if (mode == ecc_pkg::MODE_OFF) begin
      mode_class = ECC_CLASS_OFF;
    end else if (mode[3:2] == 2'h1) begin
      mode_class = ECC_CLASS_CAP;
    end else if (mode == ecc_pkg::MODE_CMP_TOGGLE || mode[3:2] == 2'h2) begin
      mode_class = ECC_CLASS_CMP;
    end else begin
      mode_class = ECC_CLASS_OFF; // reserved codes and pwm: no cap/cmp
    end
  end

  //////////////////////////////////////////////////////////////////////
  // wishbone slave: ack one cycle after request, dropped next cycle
  assign wr_en = i_wb_cyc && i_wb_stb && i_wb_we && !ack_q;
  assign rd_en = i_wb_cyc && i_wb_stb && !i_wb_we && !ack_q;
  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdata_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= i_wb_cyc && i_wb_stb && !ack_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_en) begin
      case (i_wb_adr)
        ecc_pkg::ADDR_CONTROL: rdata_q <= {24'h00_0000, control_q};
        ecc_pkg::ADDR_VALUE_LOW: rdata_q <= {24'h00_0000, value_q[7:0]};
        ecc_pkg::ADDR_VALUE_HIGH: rdata_q <= {24'h00_0000, value_q[15:8]};
        ecc_pkg::ADDR_FLAGS: rdata_q <= {29'h0000_0000, adc_enable_q,
                                         irq_enable_q, event_flag_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      control_q <= ecc_pkg::CONTROL_RESET;
    end else if (wr_en && i_wb_adr == ecc_pkg::ADDR_CONTROL && i_wb_sel[0]) begin
      control_q <= i_wb_dat[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // capture path: the pin is sampled as is, whichever way it is driven
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= i_event_pin;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  assign rise = pin_sync_q && !pin_prev_q;
  assign fall = !pin_sync_q && pin_prev_q;

  // counter only clears when leaving capture, not on code change
  ecc_edge_prescaler u_prescale (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clear(mode_class != ECC_CLASS_CAP),
    .i_rise(rise),
    .i_wrap_at(mode == ecc_pkg::MODE_CAP_RISE16 ? ecc_pkg::PRESCALE_MAX16
                                                : ecc_pkg::PRESCALE_MAX4),
    .o_wrap(wrap)
  );

  always_comb begin
    case (mode)
      ecc_pkg::MODE_CAP_FALL: capture = fall;
      ecc_pkg::MODE_CAP_RISE: capture = rise;
      ecc_pkg::MODE_CAP_RISE4: capture = wrap;
      ecc_pkg::MODE_CAP_RISE16: capture = wrap;
      default: capture = 1'b0;
    endcase
  end

  // register pair doubles as compare value; software writes it too
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      value_q <= 16'h0000;
    end else if (capture) begin
      value_q <= i_timer_one_count;
    end else if (wr_en && i_wb_adr == ecc_pkg::ADDR_VALUE_LOW) begin
      value_q <= ecc_merge(value_q, {16'h0000, value_q[15:8], i_wb_dat[7:0]},
                           {24'h00_0000, {8{i_wb_sel[0]}}});
    end else if (wr_en && i_wb_adr == ecc_pkg::ADDR_VALUE_HIGH) begin
      value_q <= ecc_merge(value_q, {16'h0000, i_wb_dat[7:0], value_q[7:0]},
                           {16'h0000, {8{i_wb_sel[0]}}, 8'h00});
    end
  end

  //////////////////////////////////////////////////////////////////////
  // compare path: act once per match; a slow timer holds it many clocks
  assign match = (mode_class == ECC_CLASS_CMP)
                 && (value_q == i_timer_one_count);
  assign hit = match && !match_q;

  always_ff @(posedge i_clk) begin
    match_q <= match && !i_rst;
    if (i_rst || mode == ecc_pkg::MODE_OFF) begin
      cmp_latch_q <= 1'b0;
    end else if (hit) begin
      case (mode)
        ecc_pkg::MODE_CMP_TOGGLE: cmp_latch_q <= !cmp_latch_q;
        ecc_pkg::MODE_CMP_SET: cmp_latch_q <= 1'b1;
        ecc_pkg::MODE_CMP_CLEAR: cmp_latch_q <= 1'b0;
        default: cmp_latch_q <= cmp_latch_q;
      endcase
    end
  end

  // flag: hardware set wins over a same-cycle software clear
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      event_flag_q <= 1'b0;
      irq_enable_q <= 1'b0;
      adc_enable_q <= 1'b0;
    end else begin
      if (capture || hit) begin
        event_flag_q <= 1'b1;
      end else if (wr_en && i_wb_adr == ecc_pkg::ADDR_FLAGS && i_wb_sel[0]) begin
        event_flag_q <= i_wb_dat[ecc_pkg::FLAG_EVENT_BIT];
      end
      if (wr_en && i_wb_adr == ecc_pkg::ADDR_FLAGS && i_wb_sel[0]) begin
        irq_enable_q <= i_wb_dat[ecc_pkg::FLAG_ENABLE_BIT];
        adc_enable_q <= i_wb_dat[ecc_pkg::FLAG_ADC_EN_BIT];
      end
    end
  end

  // special event: one pulse per match, timer reset on the next tick
  always_ff @(posedge i_clk) begin
    if (i_rst || mode != ecc_pkg::MODE_CMP_SPECIAL) begin
      special_q <= 1'b0;
    end else begin
      special_q <= hit;
    end
  end

  assign o_special_event = special_q;
  // match removed before the tick cancels the reset; separate strobe,
  // so overflow flag logic never sees it
  assign o_timer_one_reset = (mode == ecc_pkg::MODE_CMP_SPECIAL) && match
                             && i_timer_one_tick;
  assign o_adc_start = special_q && adc_enable_q;

  //////////////////////////////////////////////////////////////////////
  // pin steering; the pwm engine itself lives outside
  logic mod_a;
  logic mod_b;
  logic mod_c;
  logic mod_d;
  logic pol_ac_low;
  logic pol_bd_low;

  always_comb begin
    pol_ac_low = mode[1];
    pol_bd_low = (mode != ecc_pkg::MODE_PWM_HH);
    mod_a = 1'b0;
    mod_b = 1'b0;
    mod_c = 1'b0;
    mod_d = 1'b0;
    o_steer_owned = 4'h1;
    case (steer)
      ecc_pkg::STEER_SINGLE: begin
        mod_a = i_pwm_active;
      end
      ecc_pkg::STEER_FWD: begin
        mod_a = 1'b1;
        mod_d = i_pwm_active;
        o_steer_owned = 4'hf;
      end
      ecc_pkg::STEER_HALF: begin
        mod_a = i_pwm_active;
        mod_b = !i_pwm_active; // dead band applied by pwm engine
        o_steer_owned = 4'h3;
      end
      default: begin
        mod_c = 1'b1;
        mod_b = i_pwm_active;
        o_steer_owned = 4'hf;
      end
    endcase
    if (!is_pwm) begin
      o_steer_owned = 4'h1;
    end
  end

  logic pin_a_q;
  logic pin_b_q;
  logic pin_c_q;
  logic pin_d_q;
  logic pin_oe_n_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b0;
      pin_c_q <= 1'b0;
      pin_d_q <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end else if (is_pwm) begin
      pin_a_q <= mod_a ^ pol_ac_low;
      pin_b_q <= mod_b ^ pol_bd_low;
      pin_c_q <= mod_c ^ pol_ac_low;
      pin_d_q <= mod_d ^ pol_bd_low;
      pin_oe_n_q <= 1'b0;
    end else begin
      pin_a_q <= cmp_latch_q;
      pin_b_q <= 1'b0;
      pin_c_q <= 1'b0;
      pin_d_q <= 1'b0;
      // soft and special modes leave the pin alone
      pin_oe_n_q <= !(mode == ecc_pkg::MODE_CMP_TOGGLE
                      || mode == ecc_pkg::MODE_CMP_SET
                      || mode == ecc_pkg::MODE_CMP_CLEAR);
    end
  end

  assign o_event_pin = pin_a_q;
  assign o_event_pin_oe_n = pin_oe_n_q;
  assign o_drive_out_b = pin_b_q;
  assign o_drive_out_c = pin_c_q;
  assign o_drive_out_d = pin_d_q;
  assign o_duty = {value_q[7:0], control_q[ecc_pkg::DUTY_LSB +: 2]};
  assign o_unit_event_flag = event_flag_q;
  assign o_unit_event_irq = event_flag_q && irq_enable_q;
endmodule : ecc_unit

// ---- sim/ecc_pin_source.sv ----
`timescale 1ns/1ns
module ecc_pin_source (
  input wire logic i_level,
  output logic o_pin
);
  // edges land mid-cycle, 13 ns after the clock edge that set the level
  initial o_pin = 1'b0;
  always @(i_level) o_pin <= #13 i_level;
endmodule : ecc_pin_source

// ---- sim/ecc_unit_assertions.sv ----
`timescale 1ns/1ns
module ecc_unit_checker (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_timer_one_tick,
  input wire logic o_event_pin_oe_n,
  input wire logic o_unit_event_flag,
  input wire logic o_special_event,
  input wire logic o_timer_one_reset,
  input wire logic o_adc_start
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_take;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_rd_hole;
    s_take ##0 (!i_wb_we && i_wb_adr == 4'h1);
  endsequence
  a_ack_next: assert property (s_take |=> o_wb_ack)
    else $error("ack missing");
  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack too long");
  a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_stb))
    else $error("ack unrequested");
  a_hole_zero: assert property (s_rd_hole |=> o_wb_dat == 32'h0)
    else $error("unmapped read nonzero");
  a_flag_sticky: assert property ($fell(o_unit_event_flag)
    |-> $past(i_wb_we && i_wb_stb)) else $error("flag self cleared");
  a_reset_state: assert property ($past(i_rst) |-> !o_wb_ack
    && o_event_pin_oe_n && !o_unit_event_flag) else $error("bad reset");
  a_adc_special: assert property (o_adc_start |-> o_special_event)
    else $error("adc without event");
  a_special_flag: assert property ($rose(o_special_event)
    |-> o_unit_event_flag) else $error("event without flag");
  a_treset_tick: assert property (o_timer_one_reset
    |-> i_timer_one_tick) else $error("timer reset off tick");
  a_event_once: assert property (o_special_event
    |=> !o_special_event) else $error("special event too long");
endmodule : ecc_unit_checker
////////////////////////////////////////////////////////////////////////
bind ecc_unit ecc_unit_checker u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .i_timer_one_tick(i_timer_one_tick),
  .o_event_pin_oe_n(o_event_pin_oe_n),
  .o_unit_event_flag(o_unit_event_flag),
  .o_special_event(o_special_event),
  .o_timer_one_reset(o_timer_one_reset), .o_adc_start(o_adc_start)
);

// ---- sim/ecc_unit_tb.sv ----
`timescale 1ns/1ns
module ecc_unit_tb;
  logic i_clk = 1'b0, i_rst = 1'b1, req = 1'b0, we = 1'b0;
  logic tick = 1'b0, pin_req = 1'b0, pwm = 1'b0;
  logic [3:0] adr = 4'h0, owned;
  logic [31:0] dat = 32'h0, rdat, r;
  logic [15:0] cnt = 16'h0;
  logic ack, ev_pin, oe_n, flag, irq, spec, trst, adc;
  logic drv_b, drv_c, drv_d;
  logic [9:0] duty;
  wire logic pin;
  int n_mismatch = 0;
  int check_count = 0;
  ecc_pin_source src (.i_level(pin_req), .o_pin(pin));
  ecc_unit dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(req), .i_wb_stb(req),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(dat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_timer_one_count(cnt),
    .i_timer_one_tick(tick), .i_event_pin(pin), .i_pwm_active(pwm),
    .o_event_pin(ev_pin), .o_event_pin_oe_n(oe_n),
    .o_drive_out_b(drv_b), .o_drive_out_c(drv_c), .o_drive_out_d(drv_d),
    .o_steer_owned(owned), .o_duty(duty), .o_unit_event_flag(flag),
    .o_unit_event_irq(irq), .o_special_event(spec),
    .o_timer_one_reset(trst), .o_adc_start(adc)
  );
  initial forever #20 i_clk = ~i_clk;
  ////////////////////////////////////////////////////////////////////
  task automatic summarize;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] s, e, input string nm);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : step
  // hold the request until ack is sampled, then drop it
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge i_clk); while (ack !== 1'b1);
    r = rdat;
    req <= 1'b0;
  endtask : wb
  task automatic rdv(output logic [15:0] v);
    wb(1'b0, ecc_pkg::ADDR_VALUE_LOW, 32'h0);
    v[7:0] = r[7:0];
    wb(1'b0, ecc_pkg::ADDR_VALUE_HIGH, 32'h0);
    v[15:8] = r[7:0];
  endtask : rdv
  task automatic pulse;
    pin_req <= 1'b1;
    repeat (6) @(posedge i_clk);
    pin_req <= 1'b0;
    repeat (6) @(posedge i_clk);
  endtask : pulse
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(oe_n, 1'b1, "oe_n");
    wb(1'b1, 4'h1, 32'hff);
    wb(1'b0, 4'h1, 32'h0);
    chk(r, 32'h0, "unmapped");
    wb(1'b0, ecc_pkg::ADDR_CONTROL, 32'h0);
    chk(r, 32'h0, "control");
  endtask : t_reset
  task automatic t_cap(input logic [3:0] m, input int n, input logic [15:0] k);
    logic [15:0] v0, v;
    wb(1'b1, ecc_pkg::ADDR_CONTROL, 32'h0);
    wb(1'b1, ecc_pkg::ADDR_FLAGS, 32'h0);
    wb(1'b1, ecc_pkg::ADDR_CONTROL, {28'h0, m});
    rdv(v0);
    cnt <= ~k;
    repeat (n - 1) pulse();
    rdv(v);
    chk(v, v0, "early capture");
    cnt <= k;
    pulse();
    rdv(v);
    chk(v, k, "capture");
    chk(flag, 1'b1, "cap flag");
    cnt <= ~k;
    repeat (n) pulse();
    cnt <= k ^ 16'h00ff;
    repeat (n) pulse();
    rdv(v);
    chk(v, k ^ 16'h00ff, "overwrite");
  endtask : t_cap
  // counter must survive a direct prescale change
  task automatic t_keep;
    logic [15:0] v;
    wb(1'b1, ecc_pkg::ADDR_CONTROL, 32'h0);
    wb(1'b1, ecc_pkg::ADDR_CONTROL, {28'h0, ecc_pkg::MODE_CAP_RISE4});
    repeat (2) pulse();
    wb(1'b1, ecc_pkg::ADDR_CONTROL, {28'h0, ecc_pkg::MODE_CAP_RISE16});
    cnt <= 16'h2468;
    repeat (14) pulse();
    rdv(v);
    chk(v, 16'h2468, "kept count");
  endtask : t_keep
  // one-cycle match only; a held match would still toggle just once
  task automatic t_cmp(input logic [3:0] m, input logic p, input logic oe);
    wb(1'b1, ecc_pkg::ADDR_FLAGS, 32'h6);
    wb(1'b1, ecc_pkg::ADDR_CONTROL, {24'h0, 2'h2, 2'h0, m});
    cnt <= 16'h1234;
    @(posedge i_clk);
    cnt <= 16'h0;
    step(2);
    chk(ev_pin, p, "pin");
    chk(oe_n, oe, "oe_n");
    chk(irq, 1'b1, "irq");
    chk(owned, 4'h1, "owned");
  endtask : t_cmp
  task automatic t_special;
    int n = 0;
    wb(1'b1, ecc_pkg::ADDR_FLAGS, 32'h6);
    wb(1'b1, ecc_pkg::ADDR_CONTROL, {28'h0, ecc_pkg::MODE_CMP_SPECIAL});
    cnt <= 16'h1234;
    while (spec !== 1'b1 && n < 10) begin
      step(1);
      n++;
    end
    chk(spec, 1'b1, "special");
    chk(adc, 1'b1, "adc");
    chk(trst, 1'b0, "early reset");
    @(posedge i_clk);
    tick <= 1'b1;
    #1;
    chk(trst, 1'b1, "tick reset");
    @(posedge i_clk);
    tick <= 1'b0;
    cnt <= 16'h0;
  endtask : t_special
  task automatic t_pwm;
    logic [3:0] own [4] = '{4'h1, 4'hf, 4'h3, 4'hf};
    logic [3:0] lvl [4] = '{4'h1, 4'h3, 4'h2, 4'h9};
    wb(1'b1, ecc_pkg::ADDR_VALUE_LOW, 32'h5a);
    pwm <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, ecc_pkg::ADDR_CONTROL, {24'h0, 2'(i), 2'(i), 4'hc + 4'(i)});
      step(2);
      chk(owned, own[i], "owned");
      chk(duty, {8'h5a, 2'(i)}, "duty");
      if (i < 3) chk(ev_pin, i < 2, "pol a");
      chk({drv_d, drv_c, drv_b, ev_pin} & own[i], lvl[i], "levels");
    end
  endtask : t_pwm
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    step(1);
    t_reset();
    t_cap(4'h4, 1, 16'ha5c3);
    t_cap(4'h5, 1, 16'h3c5a);
    t_cap(4'h6, 4, 16'h0ff1);
    t_cap(4'h7, 16, 16'hbeef);
    t_keep();
    wb(1'b1, ecc_pkg::ADDR_CONTROL, 32'h0);
    wb(1'b1, ecc_pkg::ADDR_VALUE_LOW, 32'h34);
    wb(1'b1, ecc_pkg::ADDR_VALUE_HIGH, 32'h12);
    t_cmp(4'h8, 1'b1, 1'b0);
    t_cmp(4'h9, 1'b0, 1'b0);
    t_cmp(4'h2, 1'b1, 1'b0);
    t_cmp(4'ha, 1'b1, 1'b1);
    t_special();
    t_pwm();
    wb(1'b1, ecc_pkg::ADDR_CONTROL, 32'h0);
    step(2);
    chk(ev_pin, 1'b0, "off latch");
    chk(oe_n, 1'b1, "off oe_n");
    summarize();
  end
endmodule : ecc_unit_tb
